/* tfw_pkg.sv */
// Package with the constants and types of the tape frame and word datapath
package tfw_pkg;
  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_TOGGLE = 4'h8;
  localparam logic [3:0]  REG_FRAMES = 4'hc;
  // ==========================================================
  // Control fields
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_REVERSE = 2;
  localparam int CTRL_MINUS1  = 3;
  localparam int CTRL_START   = 4;
  localparam logic [1:0] MODE_IDLE  = 2'h0;
  localparam logic [1:0] MODE_READ  = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  // ==========================================================
  // Status fields
  localparam int ST_CHAR_ERR = 0;
  localparam int ST_CHAN_ERR = 1;
  localparam int ST_ERR_FLAG = 2;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_UNDERRUN = 4;
  localparam int ST_BUSY     = 5;
  // ==========================================================
  // Frame and block geometry
  localparam int FRAME_BITS   = 14;
  localparam int STAGE_BITS   = 12;
  localparam int WORD_BITS    = 48;
  localparam int HALF_BITS    = 24;
  localparam logic [9:0] BLOCK_FRAMES = 10'h200;
  localparam logic [7:0] BLOCK_WORDS  = 8'h80;
  localparam logic [1:0] LAST_SLOT    = 2'h3;
  localparam logic [2:0] FRAMES_PER_WORD = 3'h4;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_TIME_NS = 22000;
  localparam int FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYCLES - 1);
  // Write block phases
  typedef enum logic [1:0] {W_IDLE, W_DUMMY, W_DATA, W_CHPAR} tfw_phase_t;
endpackage

/* tfw_datapath.sv */
// Tape frame to word datapath of one tape access unit, with Avalon-MM register slave
// ==========================================================
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module tfw_datapath (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [13:0] head_bits,
  input  wire logic        sprocket_even,
  input  wire logic        sprocket_odd,
  output logic [13:0]      write_head_current,
  output logic             read_path_en,
  output logic             write_path_en,
  output logic [47:0]      host_io_word,
  output logic             xfer_req,
  input  wire logic        xfer_grant,
  input  wire logic [47:0] host_io_in,
  output logic             fetch_req,
  input  wire logic        fetch_grant
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [13:0]        frame_capture_buffer;
    logic [47:0]        word_assembly_shifter;
    logic [47:0]        word_holding_register;
    logic [13:0]        toggles;
    logic [1:0]         cnt_even;
    logic [1:0]         cnt_odd;
    logic               full_even;
    logic               full_odd;
    logic               word_err;
    logic               error_flag_bit;
    logic               char_err;
    logic               overrun;
    logic               underrun;
    logic [1:0]         mode;
    logic               reverse;
    logic               minus_one;
    tfw_pkg::tfw_phase_t phase;
    logic [9:0]         frame_cnt;
    logic [11:0]        tick_cnt;
    logic [2:0]         slots;
    logic               wbr_valid;
    logic [7:0]         words_fetched;
    logic               fetch_req;
    logic               xfer_req;
    logic [47:0]        host_io_word;
    logic               wait_rq;
    logic [31:0]        readdata;
    logic               rd_en;
    logic               wr_en;
  } tfw_state_t;

  tfw_state_t st;
  tfw_state_t next_st;

  // ==========================================================
  // Helpers
  // Gather one character half: slot k of a half is 6 bits of stage k
  function automatic logic [23:0] get_half(input logic [47:0] w, input logic odd);
    logic [23:0] h;
    h = '0;
    for (int k = 0; k < 4; k++) begin
      h[6*k +: 6] = w[12*k + (odd ? 6 : 0) +: 6];
    end
    return h;
  endfunction

  function automatic logic [47:0] put_half(input logic [47:0] w, input logic odd, input logic [23:0] h);
    logic [47:0] r;
    r = w;
    for (int k = 0; k < 4; k++) begin
      r[12*k + (odd ? 6 : 0) +: 6] = h[6*k +: 6];
    end
    return r;
  endfunction

  // Odd parity: parity bit sits above the six data bits of each character
  function automatic logic [13:0] enc_frame(input logic [11:0] d);
    return {~^d[11:6], d[11:6], ~^d[5:0], d[5:0]};
  endfunction

  function automatic logic par_ok(input logic [6:0] c);
    return ^c;
  endfunction

  wire        bus_ack  = (avs_read || avs_write) && !st.wait_rq;
  wire        tick     = (st.tick_cnt == tfw_pkg::FRAME_LAST);
  wire        chan_err = (st.mode == tfw_pkg::MODE_READ) && (|st.toggles);

  // ==========================================================
  // Next state
  always_comb begin
    logic [23:0] h;
    logic [6:0]  ch;
    logic        odd;
    logic        spr;
    logic [1:0]  cnt;
    logic [31:0] sts;
    next_st = st;
    h = '0;
    ch = '0;
    odd = 1'b0;
    spr = 1'b0;
    cnt = '0;
    sts = {26'h0, st.phase != tfw_pkg::W_IDLE, st.underrun, st.overrun,
           st.error_flag_bit, chan_err, st.char_err};

    // Bus slave: one wait cycle per access, write lands on the ack edge
    next_st.wait_rq = !((avs_read || avs_write) && st.wait_rq);
    if ((avs_read || avs_write) && st.wait_rq) begin
      case (avs_address)
        tfw_pkg::REG_CTRL:   next_st.readdata = {27'h0, 1'b0, st.minus_one, st.reverse, st.mode};
        tfw_pkg::REG_STATUS: next_st.readdata = sts;
        tfw_pkg::REG_TOGGLE: next_st.readdata = {18'h0, st.toggles};
        tfw_pkg::REG_FRAMES: next_st.readdata = {22'h0, st.frame_cnt};
        default:             next_st.readdata = 32'h0;
      endcase
    end

    // Write one to clear, applied before the events so that a same-cycle set wins
    if (avs_write && bus_ack && avs_address == tfw_pkg::REG_STATUS) begin
      next_st.char_err       = st.char_err & ~avs_writedata[tfw_pkg::ST_CHAR_ERR];
      next_st.error_flag_bit = st.error_flag_bit & ~avs_writedata[tfw_pkg::ST_ERR_FLAG];
      next_st.overrun        = st.overrun & ~avs_writedata[tfw_pkg::ST_OVERRUN];
      next_st.underrun       = st.underrun & ~avs_writedata[tfw_pkg::ST_UNDERRUN];
    end

    // Frame buffer picks up head bits while the read path is enabled
    if (st.mode != tfw_pkg::MODE_IDLE) begin
      next_st.frame_capture_buffer = st.frame_capture_buffer | head_bits;
    end

    // Host grant frees the holding register
    if (st.xfer_req && xfer_grant) begin
      next_st.xfer_req  = 1'b0;
      next_st.full_even = 1'b0;
      next_st.full_odd  = 1'b0;
      next_st.word_holding_register = '0;
    end

    // Character sprockets, each half on its own
    for (int i = 0; i < 2; i++) begin
      odd = (i == 1);
      spr = odd ? sprocket_odd : sprocket_even;
      if (spr && st.mode != tfw_pkg::MODE_IDLE) begin
        ch = odd ? st.frame_capture_buffer[13:7] : st.frame_capture_buffer[6:0];
        if (!par_ok(ch)) begin
          next_st.char_err = 1'b1;
          next_st.word_err = 1'b1;
        end
        if (st.mode == tfw_pkg::MODE_READ) begin
          // Parity bit stays behind; the toggles see the whole character
          if (odd) begin
            next_st.toggles[13:7] = next_st.toggles[13:7] ^ ch;
          end else begin
            next_st.toggles[6:0] = next_st.toggles[6:0] ^ ch;
          end
          h = get_half(next_st.word_assembly_shifter, odd);
          if (st.reverse) begin
            h = {ch[5:0], h[23:6]};
          end else begin
            h = {h[17:0], ch[5:0]};
          end
          cnt = odd ? st.cnt_odd : st.cnt_even;
          if (cnt == tfw_pkg::LAST_SLOT) begin
            // Word half complete: hand it over and free the shifter half at once
            if (odd ? next_st.full_odd : next_st.full_even) begin
              next_st.overrun = 1'b1;
            end else if (!st.minus_one) begin
              next_st.word_holding_register = put_half(next_st.word_holding_register, odd, h);
            end
            if (odd) begin
              next_st.full_odd = 1'b1;
            end else begin
              next_st.full_even = 1'b1;
            end
            h = '0;
          end
          next_st.word_assembly_shifter = put_half(next_st.word_assembly_shifter, odd, h);
          if (odd) begin
            next_st.cnt_odd = cnt + 2'h1;
          end else begin
            next_st.cnt_even = cnt + 2'h1;
          end
        end
        // Section cleared; bits arriving in this cycle are dropped
        if (odd) begin
          next_st.frame_capture_buffer[13:7] = 7'h0;
        end else begin
          next_st.frame_capture_buffer[6:0] = 7'h0;
        end
      end
    end

    // Both halves held: raise the request
    if (next_st.full_even && next_st.full_odd && !next_st.xfer_req) begin
      next_st.xfer_req = 1'b1;
      if (st.minus_one) begin
        if (next_st.word_err) begin
          next_st.error_flag_bit = 1'b1;
        end
        next_st.host_io_word = {47'h0, next_st.word_err};
      end else begin
        next_st.host_io_word = next_st.word_holding_register;
      end
      next_st.word_err = 1'b0;
    end

    // Write block: fetch words, load the shifter, write frames on the cadence
    if (st.phase != tfw_pkg::W_IDLE) begin
      next_st.tick_cnt = tick ? 12'h0 : st.tick_cnt + 12'h1;
    end
    if (st.fetch_req && fetch_grant) begin
      next_st.fetch_req = 1'b0;
      next_st.word_holding_register = host_io_in;
      next_st.wbr_valid = 1'b1;
      next_st.words_fetched = st.words_fetched + 8'h1;
    end else if (!st.wbr_valid && !st.fetch_req && st.words_fetched != tfw_pkg::BLOCK_WORDS &&
                 (st.phase == tfw_pkg::W_DUMMY || st.phase == tfw_pkg::W_DATA)) begin
      next_st.fetch_req = 1'b1;
    end
    if (st.phase == tfw_pkg::W_DATA && st.slots == 3'h0 && st.wbr_valid && !tick) begin
      next_st.word_assembly_shifter = st.word_holding_register;
      next_st.wbr_valid = 1'b0;
      next_st.slots = tfw_pkg::FRAMES_PER_WORD;
    end
    if (tick) begin
      case (st.phase)
        tfw_pkg::W_DUMMY: begin
          next_st.toggles = st.toggles ^ enc_frame(12'h0);
          next_st.phase = tfw_pkg::W_DATA;
        end
        tfw_pkg::W_DATA: begin
          if (st.slots == 3'h0) begin
            next_st.underrun = 1'b1;
            next_st.toggles = st.toggles ^ enc_frame(12'h0);
          end else begin
            next_st.toggles = st.toggles ^ enc_frame(st.word_assembly_shifter[47:36]);
            next_st.word_assembly_shifter = {st.word_assembly_shifter[35:0], 12'h0};
            next_st.slots = st.slots - 3'h1;
          end
          next_st.frame_cnt = st.frame_cnt + 10'h1;
          if (st.frame_cnt + 10'h1 == tfw_pkg::BLOCK_FRAMES) begin
            next_st.phase = tfw_pkg::W_CHPAR;
          end
        end
        tfw_pkg::W_CHPAR: begin
          // Clearing flips every odd channel: that is the channel parity frame
          next_st.toggles = 14'h0;
          next_st.phase = tfw_pkg::W_IDLE;
        end
        default: begin
          next_st.phase = tfw_pkg::W_IDLE;
        end
      endcase
    end

    // Register writes
    if (avs_write && bus_ack) begin
      if (avs_address == tfw_pkg::REG_CTRL) begin
        next_st.mode      = avs_writedata[tfw_pkg::CTRL_MODE_LO +: 2];
        next_st.reverse   = avs_writedata[tfw_pkg::CTRL_REVERSE];
        next_st.minus_one = avs_writedata[tfw_pkg::CTRL_MINUS1];
        if (avs_writedata[tfw_pkg::CTRL_START]) begin
          next_st.toggles = 14'h0;
          next_st.frame_capture_buffer = 14'h0;
          next_st.word_assembly_shifter = 48'h0;
          next_st.word_holding_register = 48'h0;
          next_st.cnt_even = 2'h0;
          next_st.cnt_odd = 2'h0;
          next_st.full_even = 1'b0;
          next_st.full_odd = 1'b0;
          next_st.xfer_req = 1'b0;
          next_st.fetch_req = 1'b0;
          next_st.wbr_valid = 1'b0;
          next_st.word_err = 1'b0;
          next_st.slots = 3'h0;
          next_st.frame_cnt = 10'h0;
          next_st.tick_cnt = 12'h0;
          next_st.words_fetched = 8'h0;
          next_st.phase = (avs_writedata[tfw_pkg::CTRL_MODE_LO +: 2] == tfw_pkg::MODE_WRITE) ?
                          tfw_pkg::W_DUMMY : tfw_pkg::W_IDLE;
        end
      end
    end
    // Path enables follow the mode from flip-flops of their own
    next_st.rd_en = (next_st.mode != tfw_pkg::MODE_IDLE);
    next_st.wr_en = (next_st.mode == tfw_pkg::MODE_WRITE);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.wait_rq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata       = st.readdata;
  assign avs_waitrequest    = st.wait_rq;
  assign write_head_current = st.toggles;
  assign read_path_en       = st.rd_en;
  assign write_path_en      = st.wr_en;
  assign host_io_word       = st.host_io_word;
  assign xfer_req           = st.xfer_req;
  assign fetch_req          = st.fetch_req;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_word_held: assert property (xfer_req && !xfer_grant |=> xfer_req && $stable(host_io_word))
    else $error("Read word not held until grant");
  a_req_halves: assert property ($rose(xfer_req) |-> st.full_even && st.full_odd)
    else $error("Transfer request without both halves");
  a_path_enables: assert property (write_path_en |-> read_path_en)
    else $error("Write path enabled without read path");
  a_err_word: assert property (xfer_req && st.minus_one |-> host_io_word[47:1] == 47'h0)
    else $error("Error-flag word has data bits");
  a_chpar_clear: assert property (st.phase == tfw_pkg::W_CHPAR && tick && !avs_write
                                  |=> st.toggles == 14'h0 && st.phase == tfw_pkg::W_IDLE)
    else $error("Toggles not cleared for channel parity frame");
  a_read_toggle: assert property (st.mode == tfw_pkg::MODE_READ && sprocket_even && !avs_write
                                  |=> st.toggles[6:0] == ($past(st.toggles[6:0]) ^ $past(st.frame_capture_buffer[6:0])))
    else $error("Even character not applied to toggles");
  a_buffer_clear: assert property (sprocket_even && read_path_en |=> st.frame_capture_buffer[6:0] == 7'h0)
    else $error("Frame buffer section not cleared on sprocket");
  a_write_shift: assert property (st.phase == tfw_pkg::W_DATA && tick && st.slots != 3'h0 && !avs_write
                                  |=> st.word_assembly_shifter == {$past(st.word_assembly_shifter[35:0]), 12'h0})
    else $error("Shifter not advanced after written frame");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus access not answered in one cycle");

  c_xfer: cover property (xfer_req ##1 xfer_grant);
  c_chpar: cover property (st.phase == tfw_pkg::W_CHPAR ##1 st.phase == tfw_pkg::W_IDLE);
  c_minus_err: cover property (xfer_req && st.minus_one && host_io_word[0]);
  c_overrun: cover property ($rose(st.overrun));
endmodule

/* tfw_far_side.sv */
// Partner model of the tape read heads and the host memory buffer
`timescale 1ns/1ps
module tfw_far_side (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [47:0] host_io_word,
  input  wire logic        xfer_req,
  input  wire logic        fetch_req,
  output logic [13:0]      head_bits,
  output logic             sprocket_even,
  output logic             sprocket_odd,
  output logic             xfer_grant,
  output logic             fetch_grant,
  output logic [47:0]      host_io_in
);
  int          grant_wait = 0;
  int          cnt        = 0;
  logic [47:0] fetch_word = 48'h0;
  logic [47:0] got_q [$];
  initial begin
    head_bits = 14'h0;
    sprocket_even = 1'b0;
    sprocket_odd = 1'b0;
  end
  // ==========================================================
  // Heads: the sprocket cycle carries garbage, which the buffer must ignore
  task automatic send_frame(input logic [13:0] f, input int gap, input bit skew);
    @(posedge ref_clk);
    head_bits <= f;
    @(posedge ref_clk);
    head_bits <= skew ? {f[13:7], ~f[6:0]} : ~f;
    sprocket_even <= 1'b1;
    sprocket_odd <= !skew;
    if (skew) begin
      @(posedge ref_clk);
      head_bits <= {~f[13:7], 7'h0};
      sprocket_even <= 1'b0;
      sprocket_odd <= 1'b1;
    end
    @(posedge ref_clk);
    head_bits <= 14'h0;
    sprocket_even <= 1'b0;
    sprocket_odd <= 1'b0;
    repeat (gap) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Host: grants after a set wait; fetch data is only valid with its grant
  always @(posedge ref_clk) begin
    if (reset) begin
      xfer_grant <= 1'b0;
      fetch_grant <= 1'b0;
      host_io_in <= 48'h0;
      cnt <= 0;
    end else begin
      xfer_grant <= 1'b0;
      fetch_grant <= 1'b0;
      host_io_in <= ~fetch_word;
      if ((xfer_req && !xfer_grant) || (fetch_req && !fetch_grant)) begin
        cnt <= cnt + 1;
        if (cnt >= grant_wait) begin
          cnt <= 0;
          xfer_grant <= xfer_req;
          fetch_grant <= fetch_req;
          host_io_in <= fetch_word;
        end
      end
      if (xfer_req && xfer_grant)
        got_q.push_back(host_io_word);
    end
  end
endmodule

/* tfw_datapath_tb.sv */
// Self-checking testbench of the tape frame and word datapath
`timescale 1ns/1ps
module tfw_datapath_tb;
  logic        ref_clk         = 1'b0;
  logic        reset           = 1'b1;
  logic [3:0]  avs_address     = 4'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [13:0] head_bits;
  logic [13:0] write_head_current;
  logic        sprocket_even;
  logic        sprocket_odd;
  logic        read_path_en;
  logic        write_path_en;
  logic [47:0] host_io_word;
  logic [47:0] host_io_in;
  logic        xfer_req;
  logic        xfer_grant;
  logic        fetch_req;
  logic        fetch_grant;
  logic [31:0] rd;
  logic [13:0] tog;
  logic [47:0] ef;
  logic [47:0] er;
  logic [47:0] e1;
  int          n;
  int          num_errors      = 0;
  int          samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  tfw_datapath dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .head_bits(head_bits), .sprocket_even(sprocket_even),
    .sprocket_odd(sprocket_odd), .write_head_current(write_head_current), .read_path_en(read_path_en),
    .write_path_en(write_path_en), .host_io_word(host_io_word), .xfer_req(xfer_req), .xfer_grant(xfer_grant),
    .host_io_in(host_io_in), .fetch_req(fetch_req), .fetch_grant(fetch_grant));
  tfw_far_side far_u (.ref_clk(ref_clk), .reset(reset), .host_io_word(host_io_word), .xfer_req(xfer_req),
    .fetch_req(fetch_req), .head_bits(head_bits), .sprocket_even(sprocket_even), .sprocket_odd(sprocket_odd),
    .xfer_grant(xfer_grant), .fetch_grant(fetch_grant), .host_io_in(host_io_in));
  // ==========================================================
  // Helpers
  function automatic logic [13:0] mk(input logic [11:0] s);
    return {~^s[11:6], s[11:6], ~^s[5:0], s[5:0]};
  endfunction
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("mismatch %s expected done seen timeout", what);
    final_report();
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) timeout("bus");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Frames spaced so a word takes longer than the slowest grant, as on real tape
  task automatic send_word(input logic [11:0] base, input bit skew, input bit bad);
    logic [11:0] s;
    logic [13:0] f;
    for (int k = 0; k < 4; k++) begin
      s = base + 12'(k) * 12'h111;
      f = mk(s);
      if (bad && k == 2) f[6] = ~f[6];
      ef = {ef[35:0], s};
      er = {s, er[47:12]};
      tog ^= f;
      far_u.send_frame(f, 15, skew);
    end
  endtask
  task automatic wait_word(input int want);
    int i;
    for (i = 0; i < 3000 && far_u.got_q.size() < want; i++) @(posedge ref_clk);
    if (i == 3000) timeout("word");
  endtask
  task automatic wait_change(output int cyc);
    logic [13:0] prev;
    prev = write_head_current;
    for (cyc = 1; cyc <= 2300; cyc++) begin
      @(posedge ref_clk);
      if (write_head_current !== prev) break;
    end
    if (cyc > 2300) timeout("head current");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    bus(1'b0, tfw_pkg::REG_STATUS, 32'h0);
    chk("status reset", 48'h0, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", 48'h0, rd);
    chk("idle enables", 48'h0, {read_path_en, write_path_en});
    $display("test reset done");
    // Slow grant: first word waits while the second one assembles
    far_u.grant_wait = 40;
    tog = 14'h0;
    bus(1'b1, tfw_pkg::REG_CTRL, 32'h11);
    repeat (2) @(posedge ref_clk);
    chk("read enables", 48'h2, {read_path_en, write_path_en});
    send_word(12'h5a3, 1'b0, 1'b0);
    e1 = ef;
    send_word(12'h0c7, 1'b0, 1'b0);
    wait_word(2);
    chk("fwd word 1", e1, far_u.got_q.pop_front());
    chk("fwd word 2", ef, far_u.got_q.pop_front());
    bus(1'b0, tfw_pkg::REG_TOGGLE, 32'h0);
    chk("toggles", tog, rd[13:0]);
    bus(1'b0, tfw_pkg::REG_STATUS, 32'h0);
    chk("chan err", |tog, rd[tfw_pkg::ST_CHAN_ERR]);
    chk("char err", 48'h0, rd[tfw_pkg::ST_CHAR_ERR]);
    $display("test forward read done");
    tog = 14'h0;
    bus(1'b1, tfw_pkg::REG_CTRL, 32'h15);
    send_word(12'h2e9, 1'b1, 1'b0);
    wait_word(1);
    chk("rev word", er, far_u.got_q.pop_front());
    $display("test reverse read done");
    tog = 14'h0;
    bus(1'b1, tfw_pkg::REG_CTRL, 32'h19);
    send_word(12'h3b1, 1'b0, 1'b1);
    send_word(12'h4d2, 1'b0, 1'b0);
    wait_word(2);
    chk("flag word bad", 48'h1, far_u.got_q.pop_front());
    chk("flag word good", 48'h0, far_u.got_q.pop_front());
    bus(1'b0, tfw_pkg::REG_STATUS, 32'h0);
    chk("flag status", {1'b1, |tog, 1'b1}, rd[2:0]);
    bus(1'b1, tfw_pkg::REG_STATUS, 32'h5);
    bus(1'b0, tfw_pkg::REG_STATUS, 32'h0);
    chk("flags cleared", {1'b0, |tog, 1'b0}, rd[2:0]);
    $display("test error flag read done");
    // Write block: dummy, then frames from the fetched word
    far_u.grant_wait = 3;
    far_u.fetch_word = 48'h8e1_2d7_000_000;
    bus(1'b1, tfw_pkg::REG_CTRL, 32'h12);
    repeat (2) @(posedge ref_clk);
    chk("write enables", 48'h3, {read_path_en, write_path_en});
    chk("cleared", 48'h0, write_head_current);
    wait_change(n);
    chk("dummy frame", 48'h2040, write_head_current);
    wait_change(n);
    chk("frame period", 48'h898, 48'(n));
    tog = 14'h2040 ^ mk(12'h8e1);
    chk("data frame 1", tog, write_head_current);
    far_u.send_frame(14'h0001, 2, 1'b0);
    bus(1'b0, tfw_pkg::REG_STATUS, 32'h0);
    chk("readback parity", 48'h1, rd[tfw_pkg::ST_CHAR_ERR]);
    chk("write busy", 48'h1, rd[tfw_pkg::ST_BUSY]);
    chk("readback no toggle", tog, write_head_current);
    wait_change(n);
    chk("data frame 2", tog ^ mk(12'h2d7), write_head_current);
    bus(1'b0, tfw_pkg::REG_FRAMES, 32'h0);
    chk("frame count", 48'h2, rd);
    $display("test write done");
    bus(1'b1, tfw_pkg::REG_CTRL, 32'h0);
    final_report();
  end
endmodule
